// [core/trc_tx_clock_rate_control.sv]
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module trc_tx_clock_rate_control #(
    parameter int CNT_W   = 8,
    parameter int PHASE_W = 8
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      reference_clock_in,
    input  wire logic                      tx_input_clock,
    input  wire logic [trc_pkg::WORD_W-1:0] tx_data_in,
    output logic                           tx_synth_clock_out_p,
    output logic                           tx_synth_clock_out_n,
    output logic                           rx_char_clock_out_p,
    output logic                           rx_char_clock_out_n,
    output logic                           rx_delayed_reference_out,
    output logic                           rx_delayed_reference_out_oe_n,
    output logic [4:0]                     tx_pll_multiplier,
    output logic [3:0]                     tx_mode_index,
    output logic                           tx_config_invalid,
    output logic [trc_pkg::WORD_W-1:0]     tx_input_word
);
    // Refuse widths the period counter and phase field cannot serve
    if (CNT_W < 4 || PHASE_W < 1 || PHASE_W > CNT_W || PHASE_W > 16) begin : g_bad_param
        $error("trc: unsupported CNT_W or PHASE_W");
    end

    typedef enum logic {TRC_ADJUST = 1'b0, TRC_LOCKED = 1'b1} trc_phase_st_t;

    logic [10:0]              ctrl_r;
    logic                     ref_d_r;
    logic                     txc_d_r;
    logic [CNT_W-1:0]         cnt_r;
    logic [CNT_W-1:0]         period_r;
    logic [CNT_W-1:0]         sub_r;
    logic [1:0]               tgl_r;
    logic                     dbl_r;
    logic                     txo_r;
    logic                     rxo_r;
    logic                     rxd_r;
    logic [PHASE_W-1:0]       phase_r;
    trc_phase_st_t            st_r;
    logic [trc_pkg::WORD_W-1:0] word_r;

    // Floating code is taken as mid
    function automatic logic [1:0] trc_decode(input logic [1:0] code);
        trc_decode = (code == trc_pkg::TRC_LVL_FLOAT) ? 2'(trc_pkg::TRC_LVL_MID) : code;
    endfunction

    wire       rate     = ctrl_r[trc_pkg::CTRL_RATE_BIT];
    wire [1:0] rxsrc    = trc_decode(ctrl_r[trc_pkg::CTRL_RXSRC_LSB +: 2]);
    wire [1:0] txsrc    = trc_decode(ctrl_r[trc_pkg::CTRL_TXSRC_LSB +: 2]);
    wire [1:0] mode0    = trc_decode(ctrl_r[trc_pkg::CTRL_MODE0_LSB +: 2]);
    wire [1:0] mode1    = trc_decode(ctrl_r[trc_pkg::CTRL_MODE1_LSB +: 2]);
    wire       parst    = ctrl_r[trc_pkg::CTRL_PARST_BIT];
    wire       rx_ref   = (rxsrc == trc_pkg::TRC_LVL_LOW);
    wire       src_ref  = (txsrc == trc_pkg::TRC_LVL_LOW);
    wire       ref_rise = reference_clock_in & ~ref_d_r;
    wire       txc_rise = tx_input_clock & ~txc_d_r;
    wire [CNT_W-1:0] quarter = period_r >> 2;
    wire       sub_hit  = (quarter != '0) && (sub_r + 1'b1 >= quarter) && (tgl_r != 2'h3);
    wire       load_en  = src_ref ? ref_rise : txc_rise;

    assign tx_pll_multiplier = rate ? trc_pkg::MULT_HIGH : trc_pkg::MULT_LOW;
    assign tx_mode_index     = 4'(mode1 * trc_pkg::MODE_RADIX) + 4'(mode0);
    assign tx_config_invalid = rate & ~src_ref;

    wire bus_acc  = psel & penable;
    wire hit_ctrl = (paddr == trc_pkg::OFS_CTRL);
    wire hit_stat = (paddr == trc_pkg::OFS_STATUS);
    wire hit_word = (paddr == trc_pkg::OFS_WORD);
    wire mapped   = hit_ctrl | hit_stat | hit_word;
    wire wr_ctrl  = bus_acc & pwrite & hit_ctrl & ce;

    wire [31:0] status_word = (32'(tx_pll_multiplier) << trc_pkg::STAT_MULT_LSB)
                            | (32'(tx_config_invalid) << trc_pkg::STAT_INVAL_BIT)
                            | (32'(tx_mode_index) << trc_pkg::STAT_MODE_LSB)
                            | (32'(st_r == TRC_LOCKED) << trc_pkg::STAT_LOCK_BIT)
                            | (32'(rx_ref & rate) << trc_pkg::STAT_RXHALF_BIT)
                            | (32'(phase_r) << trc_pkg::STAT_PHASE_LSB);

    assign pready  = 1'b1;
    assign pslverr = bus_acc & ~mapped;
    assign prdata  = hit_ctrl ? 32'(ctrl_r) : hit_stat ? status_word : hit_word ? 32'(word_r) : 32'h0000_0000;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= trc_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= pwdata[10:0];
        end
    end

    // Reference period measurement drives the doubled clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_d_r  <= 1'b0;
            txc_d_r  <= 1'b0;
            cnt_r    <= '0;
            period_r <= '0;
            sub_r    <= '0;
            tgl_r    <= 2'h0;
            dbl_r    <= 1'b0;
        end else if (ce) begin
            ref_d_r <= reference_clock_in;
            txc_d_r <= tx_input_clock;
            if (ref_rise) begin
                cnt_r    <= '0;
                period_r <= cnt_r + 1'b1;
                sub_r    <= '0;
                tgl_r    <= 2'h0;
                dbl_r    <= 1'b1;
            end else begin
                cnt_r <= (cnt_r == '1) ? cnt_r : cnt_r + 1'b1;
                if (sub_hit) begin
                    sub_r <= '0;
                    tgl_r <= tgl_r + 1'b1;
                    dbl_r <= ~dbl_r;
                end else begin
                    sub_r <= sub_r + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            txo_r <= 1'b0;
            rxo_r <= 1'b0;
            rxd_r <= 1'b0;
        end else if (ce) begin
            txo_r <= rate ? dbl_r : reference_clock_in;
            rxo_r <= rx_ref & reference_clock_in;
            rxd_r <= rx_ref & rxo_r;
        end
    end

    assign tx_synth_clock_out_p          = txo_r;
    assign tx_synth_clock_out_n          = ~txo_r;
    assign rx_char_clock_out_p           = rxo_r;
    assign rx_char_clock_out_n           = rx_ref & ~rxo_r;
    assign rx_delayed_reference_out      = rxd_r;
    assign rx_delayed_reference_out_oe_n = ~rx_ref;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r    <= TRC_ADJUST;
            phase_r <= '0;
        end else if (ce) begin
            case (st_r)
                TRC_ADJUST: begin
                    if (txc_rise) begin
                        phase_r <= cnt_r[PHASE_W-1:0];
                    end
                    if (parst) begin
                        st_r <= TRC_LOCKED;
                    end
                end
                TRC_LOCKED: begin
                    if (!parst) begin
                        st_r <= TRC_ADJUST;
                    end
                end
                default: st_r <= TRC_ADJUST;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            word_r <= '0;
        end else if (ce && load_en) begin
            word_r <= tx_data_in;
        end
    end
    assign tx_input_word = word_r;

    property p_mult;
        @(posedge sys_clk) disable iff (rst) rate |-> tx_pll_multiplier == 5'h14;
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier not twenty");

    property p_mult_low;
        @(posedge sys_clk) disable iff (rst) !rate |-> tx_pll_multiplier == 5'h0A;
    endproperty
    a_mult_low: assert property (p_mult_low) else $error("multiplier not ten");

    property p_txo_follow;
        @(posedge sys_clk) disable iff (rst) (ce && !rate) ##1 $stable(rate) |-> txo_r == $past(reference_clock_in);
    endproperty
    a_txo_follow: assert property (p_txo_follow) else $error("tx clock not following reference");

    property p_txo_compl;
        @(posedge sys_clk) disable iff (rst) tx_synth_clock_out_n != tx_synth_clock_out_p;
    endproperty
    a_txo_compl: assert property (p_txo_compl) else $error("tx clock pair not complementary");

    sequence s_rx_ref_cycle;
        ce && rx_ref ##1 rx_ref;
    endsequence
    property p_rx_follow;
        @(posedge sys_clk) disable iff (rst) s_rx_ref_cycle |-> rxo_r == $past(reference_clock_in);
    endproperty
    a_rx_follow: assert property (p_rx_follow) else $error("rx clock not following reference");

    property p_invalid;
        @(posedge sys_clk) disable iff (rst) tx_config_invalid == (rate && txsrc != 2'h0);
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid mode flag wrong");

    property p_lock_hold;
        @(posedge sys_clk) disable iff (rst) st_r == TRC_LOCKED && parst |=> $stable(phase_r);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("phase moved while locked");

    property p_mode_range;
        @(posedge sys_clk) disable iff (rst) tx_mode_index <= 4'h8;
    endproperty
    a_mode_range: assert property (p_mode_range) else $error("mode index out of range");

    property p_float_mid;
        @(posedge sys_clk) disable iff (rst) ctrl_r[5:4] == 2'h3 |-> txsrc == 2'h1;
    endproperty
    a_float_mid: assert property (p_float_mid) else $error("floating select not mid");

    property p_load;
        @(posedge sys_clk) disable iff (rst) ce && load_en |=> tx_input_word == $past(tx_data_in);
    endproperty
    a_load: assert property (p_load) else $error("input register not loaded");
endmodule // trc_tx_clock_rate_control
`default_nettype wire

// [core/trc_pkg.sv]
// Overview of operation
// - With the rate select high the serial bit clock multiplier is twenty.
// - With the rate select low the serial bit clock multiplier is ten.
// - The true and complement transmit clock follows the reference when rate is low and doubles it when high.
// - With receive clocking from the reference and rate high, both receive clocks follow the reference as half rate; the code keeps them at full rate.
// - With receive clocking from the reference and rate low, both receive clocks follow the reference as full rate.
// - While phase-align reset is low the input clock phase keeps being measured; when high it is held.
// - The two three-level mode selects pick one of nine transmit modes.
// - A three-level select decodes as low, mid or high, and a floating one counts as mid.
// - The input register loads on reference rises when the source select is low, else on input clock rises.
package trc_pkg;
    typedef enum logic [1:0] {
        TRC_LVL_LOW   = 2'h0,
        TRC_LVL_MID   = 2'h1,
        TRC_LVL_HIGH  = 2'h2,
        TRC_LVL_FLOAT = 2'h3
    } trc_level_t;

    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_WORD   = 12'h008;

    localparam int CTRL_RATE_BIT   = 0;
    localparam int CTRL_RXSRC_LSB  = 2;
    localparam int CTRL_TXSRC_LSB  = 4;
    localparam int CTRL_MODE0_LSB  = 6;
    localparam int CTRL_MODE1_LSB  = 8;
    localparam int CTRL_PARST_BIT  = 10;

    localparam int STAT_MULT_LSB   = 0;
    localparam int STAT_INVAL_BIT  = 5;
    localparam int STAT_MODE_LSB   = 6;
    localparam int STAT_LOCK_BIT   = 10;
    localparam int STAT_RXHALF_BIT = 11;
    localparam int STAT_PHASE_LSB  = 16;

    localparam logic [10:0] CTRL_RESET = 11'h3FC;
    localparam logic [4:0]  MULT_LOW   = 5'h0A;
    localparam logic [4:0]  MULT_HIGH  = 5'h14;
    localparam logic [3:0]  MODE_RADIX = 4'h3;
    localparam int          WORD_W     = 10;
endpackage

// [testbench/trc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module trc_host_model #(
    parameter int LAG = 3
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       reference_clock_in,
    input  wire logic                       stall,
    input  wire logic [trc_pkg::WORD_W-1:0] word_in,
    output var  logic                       tx_input_clock,
    output var  logic [trc_pkg::WORD_W-1:0] tx_data_in
);
    logic [LAG-1:0] lag_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lag_r          <= '0;
            tx_input_clock <= 1'b0;
            tx_data_in     <= '0;
        end else begin
            lag_r      <= {lag_r[LAG-2:0], reference_clock_in};
            tx_data_in <= word_in;
            if (!stall)
                tx_input_clock <= lag_r[LAG-1]; // Same rate as reference, fixed lag
        end
    end
endmodule // trc_host_model
`default_nettype wire

// [testbench/trc_tx_clock_rate_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module trc_tx_clock_rate_control_tb;
    logic        sys_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic        ref_clk, stall, tclk, tx_p, tx_n, rx_p, rx_n, rxd, oe_n, inval;
    logic        tx_q, rx_q, txn_q, rxn_q, rxd_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0]  ref_div;
    logic [4:0]  mult;
    logic [3:0]  midx;
    logic [9:0]  word, din, wq, tiw;
    logic [10:0] c;
    int          n_tx, n_rx, n_txn, n_rxn, n_rxd, failures, samples_checked;
    logic [31:0] exp_q[$], msk_q[$];
    logic        err_q[$];

    trc_tx_clock_rate_control #(.CNT_W(8), .PHASE_W(8)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_clock_in(ref_clk), .tx_input_clock(tclk), .tx_data_in(din),
        .tx_synth_clock_out_p(tx_p), .tx_synth_clock_out_n(tx_n), .rx_char_clock_out_p(rx_p),
        .rx_char_clock_out_n(rx_n), .rx_delayed_reference_out(rxd), .rx_delayed_reference_out_oe_n(oe_n),
        .tx_pll_multiplier(mult), .tx_mode_index(midx), .tx_config_invalid(inval), .tx_input_word(tiw));
    trc_host_model u_host (.sys_clk(sys_clk), .rst(rst), .reference_clock_in(ref_clk),
        .stall(stall), .word_in(word), .tx_input_clock(tclk), .tx_data_in(din));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Reference runs at one eighth of the system clock; edges are counted
    always @(posedge sys_clk) begin
        ref_div <= ref_div + 3'h1;
        ref_clk <= ref_div[2];
        tx_q    <= tx_p;
        rx_q    <= rx_p;
        txn_q   <= tx_n;
        rxn_q   <= rx_n;
        rxd_q   <= rxd;
        if (tx_p && !tx_q) n_tx <= n_tx + 1;
        if (rx_p && !rx_q) n_rx <= n_rx + 1;
        if (tx_n && !txn_q) n_txn <= n_txn + 1;
        if (rx_n && !rxn_q) n_rxn <= n_rxn + 1;
        if (rxd && !rxd_q) n_rxd <= n_rxd + 1;
    end

    task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m,
                          input logic ge, input logic ee);
        samples_checked++;
        if (((g & m) !== (e & m)) || (ge !== ee)) begin
            failures++;
            $display("mismatch at %0t: got %h/%h exp %h/%h", $time, g & m, ge, e & m, ee);
        end
    endtask

    task automatic cmp_n(input int g, input int e);
        samples_checked++;
        if (g != e) begin
            failures++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    always @(posedge sys_clk)
        if (psel && penable && pready && !pwrite)
            cmp_rd(prdata, exp_q.pop_front(), msk_q.pop_front(), pslverr, err_q.pop_front());

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m, input logic ee);
        if (!w) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
            err_q.push_back(ee);
        end
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk) penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [31:0] d);
        apb(1'b1, 12'h000, d, '0, '0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic ee);
        apb(1'b0, a, '0, e, m, ee);
    endtask

    function automatic int lvl(input logic [1:0] v);
        return (v == 2'h3) ? 1 : int'(v);
    endfunction

    function automatic logic [31:0] stat(input logic [10:0] k);
        logic [31:0] s;
        s       = '0;
        s[4:0]  = k[0] ? 5'h14 : 5'h0A;
        s[5]    = k[0] && lvl(k[5:4]) != 0;
        s[9:6]  = 4'(3 * lvl(k[9:8]) + lvl(k[7:6]));
        s[11]   = k[0] && lvl(k[3:2]) == 0;
        return s;
    endfunction

    task automatic measure(input int et, input int er);
        int a;
        int b;
        int an;
        int bn;
        int bd;
        repeat (24) @(posedge sys_clk);
        while (ref_div != 3'h0) @(posedge sys_clk);
        a  = n_tx;
        b  = n_rx;
        an = n_txn;
        bn = n_rxn;
        bd = n_rxd;
        repeat (80) @(posedge sys_clk);
        cmp_n(n_tx - a, et);
        cmp_n(n_txn - an, et);
        cmp_n(n_rx - b, er);
        cmp_n(n_rxn - bn, er);
        cmp_n(n_rxd - bd, er);
    endtask

    task automatic close_out();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {rst, ce, psel, penable, pwrite, stall, ref_clk} = 7'h40;
        {paddr, pwdata, word, ref_div, n_tx, n_rx, failures, samples_checked} = '0;
        void'($urandom(32'h14b3c888));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        ce  <= 1'b1;
        @(posedge sys_clk);
        rd(12'h000, 32'h3FC, 32'hFFFFFFFF, 1'b0);
        rd(12'h004, stat(11'h3FC), 32'hBFF, 1'b0);
        rd(12'hFFC, '0, 32'hFFFFFFFF, 1'b1);
        for (int i = 0; i < 128; i++) begin
            c = {1'b0, i[6:1], 2'($urandom), 1'b0, i[0]};
            wr({21'h0, c});
            rd(12'h004, stat(c), 32'hBFF, 1'b0);
            cmp_rd({22'h0, midx, inval, mult}, stat(c), 32'h3FF, 1'b0, 1'b0);
        end
        ce <= 1'b0;
        wr(32'h0);
        ce <= 1'b1;
        rd(12'h000, {21'h0, c}, 32'hFFFFFFFF, 1'b0);
        wr(32'h0);
        measure(10, 10);
        cmp_rd({31'h0, oe_n}, 32'h0, 32'h1, 1'b0, 1'b0);
        wr(32'h1);
        measure(20, 10);
        word  <= 10'($urandom);
        stall <= 1'b1;
        wr(32'h0);
        repeat (24) @(posedge sys_clk);
        rd(12'h008, {22'h0, word}, 32'h3FF, 1'b0);
        wr(32'h014);
        cmp_rd({31'h0, oe_n}, 32'h1, 32'h1, 1'b0, 1'b0);
        wq = word;
        word <= word ^ (10'($urandom) | 10'h1);
        repeat (24) @(posedge sys_clk);
        rd(12'h008, {22'h0, wq}, 32'h3FF, 1'b0);
        cmp_rd({22'h0, tiw}, {22'h0, wq}, 32'h3FF, 1'b0, 1'b0);
        stall <= 1'b0;
        repeat (24) @(posedge sys_clk);
        rd(12'h008, {22'h0, word}, 32'h3FF, 1'b0);
        cmp_rd({22'h0, tiw}, {22'h0, word}, 32'h3FF, 1'b0, 1'b0);
        wr(32'h400);
        rd(12'h004, 32'h400, 32'h400, 1'b0);
        wr(32'h0);
        rd(12'h004, 32'h0, 32'h400, 1'b0);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        close_out();
    end
endmodule // trc_tx_clock_rate_control_tb
`default_nettype wire
